// ### hw/rx_err_status.sv
// Functional notes
// - Error tag in any of bottom four entries raises flag bit 5 and interrupt.
// - While error flag is set, no receive DMA service request is made.
// - No tagged bottom entry clears flag and re-enables DMA requests.
// - Error flag is read-only, taken only from FIFO tag state.
// - End-of-break flag (bit 4) setting rearms the break-start flag.
// - End-of-break lets received characters enter the FIFO again.
// - Break seen then rising receive input sets end-of-break, requests interrupt.
// - During break only one null framing-error character is stored.
`timescale 1ns/1ps
module rx_err_status (
  // Clock and reset
  input  wire logic                            ref_clk,
  input  wire logic                            arst_n,
  // Characters from the shifter
  input  wire logic                            char_valid,
  output logic                                 char_ready,
  input  wire logic [uart_rx_pkg::DATA_W-1:0]  char_data,
  input  wire logic [uart_rx_pkg::TAG_W-1:0]   char_err,
  // Receive input level
  input  wire logic                            rx_in,
  // Flag clears from software, one-cycle pulses
  input  wire logic                            clear_brk_end,
  input  wire logic                            clear_brk_begin,
  // Drain side
  output logic                                 out_valid,
  input  wire logic                            out_ready,
  output logic [uart_rx_pkg::ENTRY_W-1:0]      out_data,
  // Status and requests
  output logic [uart_rx_pkg::STAT_W-1:0]       status_bits,
  output logic                                 error_in_fifo_flag,
  output logic                                 receive_end_of_break_flag,
  output logic                                 receive_break_begin_flag,
  output logic                                 dma_req,
  output logic                                 irq
);
  rx_fifo_if fq ();

  rx_tag_fifo #(
    .WIDTH (uart_rx_pkg::ENTRY_W),
    .DEPTH (uart_rx_pkg::DEPTH)
  ) u_fifo (
    .ref_clk (ref_clk),
    .arst_n  (arst_n),
    .f       (fq.fifo)
  );

  // Status flags and break state
  logic err_flag_r;
  logic brk_end_r;
  logic brk_begin_r;
  logic armed_r;
  logic brk_r;
  logic rx_prev_r;
  logic dma_r;
  logic irq_r;
  logic null_fe;
  logic rx_rise;
  logic brk_end_set;
  logic brk_begin_set;
  logic drop;
  logic brk_end_nxt;
  logic err_flag_nxt;

  assign null_fe = char_valid && (char_data == uart_rx_pkg::NULL_CHAR) &&
                   char_err[uart_rx_pkg::TAG_FRM - uart_rx_pkg::TAG_LSB];
  // Idle-high reset of rx_prev_r keeps reset from faking an edge
  assign rx_rise = rx_in && !rx_prev_r;
  assign brk_end_set   = brk_r && rx_rise;
  // Begin only when the kept null can really enter the FIFO
  assign brk_begin_set = null_fe && armed_r && !brk_r && fq.push_ready;
  assign drop    = brk_r;
  assign fq.push_valid = char_valid && !drop;
  assign fq.push_data  = {char_err, char_data};
  // Dropped chars are still taken so the shifter never stalls during a break
  assign char_ready    = drop || fq.push_ready;
  assign fq.pop_ready  = out_ready;
  assign out_valid     = fq.pop_valid;
  assign out_data      = fq.pop_data;
  assign err_flag_nxt = fq.err_bottom;
  assign brk_end_nxt  = brk_end_set || (brk_end_r && !clear_brk_end);

  // ==========================================================
  // Line edge tracking
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rx_prev_r <= 1'b1;
    end else begin
      rx_prev_r <= rx_in;
    end
  end

  // ==========================================================
  // Break interlock
  // A break opens on a null char with a framing tag; that first
  // char is kept and later ones are swallowed until the line rises.
  // A full FIFO holds the opening off, or the kept null would be lost.
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      brk_r       <= 1'b0;
      armed_r     <= 1'b1;
      brk_begin_r <= 1'b0;
      brk_end_r   <= 1'b0;
    end else begin
      if (brk_end_set) begin
        brk_r <= 1'b0;
      end else if (brk_begin_set) begin
        brk_r <= 1'b1;
      end
      if (brk_end_set) begin
        armed_r <= 1'b1;
      end else if (brk_begin_set) begin
        armed_r <= 1'b0;
      end
      // Set wins over a same-cycle clear
      if (brk_begin_set) begin
        brk_begin_r <= 1'b1;
      end else if (clear_brk_begin) begin
        brk_begin_r <= 1'b0;
      end
      brk_end_r <= brk_end_nxt;
    end
  end

  // ==========================================================
  // Error flag, DMA gate and interrupt
  // The flag follows the four oldest entries only, so a pop that
  // uncovers a clean bottom clears it with no software action.
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      err_flag_r <= 1'b0;
      dma_r      <= 1'b0;
      irq_r      <= 1'b0;
    end else begin
      err_flag_r <= err_flag_nxt;
      // DMA gated by flag
      // Gate on the next flag value so no request leaks for a cycle
      dma_r <= (fq.count >= uart_rx_pkg::DMA_THRESH) && !err_flag_nxt;
      irq_r <= err_flag_nxt || brk_end_nxt;
    end
  end

  always_comb begin
    status_bits = '0;
    status_bits[uart_rx_pkg::ERR_FIFO_BIT]  = err_flag_r;
    status_bits[uart_rx_pkg::BRK_END_BIT]   = brk_end_r;
    status_bits[uart_rx_pkg::BRK_BEGIN_BIT] = brk_begin_r;
  end
  assign error_in_fifo_flag        = err_flag_r;
  assign receive_end_of_break_flag = brk_end_r;
  assign receive_break_begin_flag  = brk_begin_r;
  assign dma_req                   = dma_r;
  assign irq                       = irq_r;

  // ==========================================================
  // Assertions
  // Registered flags are checked one edge after the state that
  // should move them.
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  sequence brk_end_s;
    brk_r && rx_rise;
  endsequence

  sequence end_up_s;
    brk_end_r && armed_r && !brk_r;
  endsequence

  sequence brk_start_s;
    null_fe && armed_r && !brk_r && fq.push_ready;
  endsequence

  sequence in_break_s;
    brk_r && char_valid;
  endsequence

  err_raise_a: assert property (
    fq.err_bottom |=> err_flag_r && irq_r)
    else $error("error flag or irq missing after tagged entry");
  dma_gate_a: assert property (
    err_flag_r |-> !dma_r)
    else $error("dma request while error flag set");
  err_clear_a: assert property (
    !fq.err_bottom |=> !err_flag_r)
    else $error("error flag stuck without tags");
  dma_resume_a: assert property (
    (fq.count >= uart_rx_pkg::DMA_THRESH && !fq.err_bottom) |=> dma_r)
    else $error("dma request not resumed");
  err_only_a: assert property (
    $stable(fq.err_bottom) && (err_flag_r == fq.err_bottom) |=>
    $stable(err_flag_r))
    else $error("error flag moved without tag change");

  rearm_on_a: assert property (
    brk_end_s |=> armed_r)
    else $error("break start not rearmed");
  no_restart_a: assert property (
    (!armed_r && !brk_begin_r && null_fe) |=> !brk_begin_r)
    else $error("break start flagged again before rearm");
  resume_store_a: assert property (
    brk_end_s |=> end_up_s)
    else $error("storage not resumed at break end");
  brk_end_a: assert property (
    brk_end_s |=> brk_end_r && irq_r)
    else $error("end of break not flagged");

  one_null_a: assert property (
    in_break_s |-> char_ready && !fq.push_valid)
    else $error("character stored during break");
  null_kept_a: assert property (
    brk_start_s |-> fq.push_valid ##1 (brk_r && brk_begin_r && !armed_r))
    else $error("opening null not stored or break not entered");
endmodule // rx_err_status

// ### hw/rx_fifo_if.sv
`timescale 1ns/1ps
interface rx_fifo_if;
  logic                            push_valid;
  logic                            push_ready;
  logic [uart_rx_pkg::ENTRY_W-1:0] push_data;
  logic                            pop_valid;
  logic                            pop_ready;
  logic [uart_rx_pkg::ENTRY_W-1:0] pop_data;
  logic [uart_rx_pkg::CNT_W-1:0]   count;
  logic                            err_bottom;

  modport fifo (input  push_valid, push_data, pop_ready,
                output push_ready, pop_valid, pop_data, count, err_bottom);
  modport ctrl (output push_valid, push_data, pop_ready,
                input  push_ready, pop_valid, pop_data, count, err_bottom);
endinterface // rx_fifo_if

// ### hw/rx_tag_fifo.sv
`timescale 1ns/1ps
module rx_tag_fifo #(
  parameter int WIDTH = uart_rx_pkg::ENTRY_W,
  parameter int DEPTH = uart_rx_pkg::DEPTH
) (
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic arst_n,
  // Both sides
  rx_fifo_if.fifo   f
);
  logic [WIDTH-1:0]              mem [DEPTH];
  logic [uart_rx_pkg::PTR_W-1:0] wr_ptr_r;
  logic [uart_rx_pkg::PTR_W-1:0] rd_ptr_r;
  logic [uart_rx_pkg::CNT_W-1:0] count_r;
  logic [uart_rx_pkg::BOTTOM_N-1:0] tag_hit;
  logic                          do_push;
  logic                          do_pop;

  assign do_push      = f.push_valid && f.push_ready;
  assign do_pop       = f.pop_valid && f.pop_ready;
  assign f.push_ready = (count_r != uart_rx_pkg::CNT_W'(DEPTH));
  assign f.pop_valid  = (count_r != '0);
  assign f.pop_data   = mem[rd_ptr_r];
  assign f.count      = count_r;

  // ==========================================================
  // Storage, no reset needed on data
  always_ff @(posedge ref_clk) begin
    if (do_push) begin
      mem[wr_ptr_r] <= f.push_data;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end else begin
      if (do_push) begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (do_pop) begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
      end
      if (do_push && !do_pop) begin
        count_r <= count_r + 1'b1;
      end else if (do_pop && !do_push) begin
        count_r <= count_r - 1'b1;
      end
    end
  end

  // ==========================================================
  // Tag scan of the bottom entries (oldest first)
  for (genvar i = 0; i < uart_rx_pkg::BOTTOM_N; i++) begin : g_bottom
    logic [uart_rx_pkg::PTR_W-1:0] idx;
    assign idx = rd_ptr_r + uart_rx_pkg::PTR_W'(i);
    assign tag_hit[i] = (count_r > uart_rx_pkg::CNT_W'(i)) &&
                        (|mem[idx][WIDTH-1:uart_rx_pkg::TAG_LSB]);
  end
  assign f.err_bottom = |tag_hit;
endmodule // rx_tag_fifo

// ### hw/uart_rx_pkg.sv
package uart_rx_pkg;
  // ==========================================================
  // Entry layout: data byte plus three error tags
  localparam int DATA_W   = 8;
  localparam int TAG_W    = 3;
  localparam int ENTRY_W  = DATA_W + TAG_W;
  localparam int TAG_LSB  = 8;
  localparam int TAG_PAR  = 8;
  localparam int TAG_FRM  = 9;
  localparam int TAG_OVR  = 10;
  // ==========================================================
  // FIFO shape
  localparam int DEPTH    = 32;
  localparam int PTR_W    = 5;
  localparam int CNT_W    = 6;
  localparam int BOTTOM_N = 4;
  localparam logic [CNT_W-1:0] DMA_THRESH = 6'h05;
  // ==========================================================
  // Status byte layout
  localparam int STAT_W   = 8;
  localparam int ERR_FIFO_BIT  = 5;
  localparam int BRK_END_BIT   = 4;
  localparam int BRK_BEGIN_BIT = 3;
  localparam logic [DATA_W-1:0] NULL_CHAR = 8'h00;
endpackage

// ### sim/drain_model.sv
`timescale 1ns/1ps
// ==========
// Drain side partner, stalls at random
module drain_model (
  // Clock and reset
  input  wire logic                            ref_clk,
  input  wire logic                            arst_n,
  // Drain handshake
  input  wire logic                            en,
  input  wire logic                            out_valid,
  output logic                                 out_ready,
  input  wire logic [uart_rx_pkg::ENTRY_W-1:0] out_data,
  // Observed pop
  output logic                                 got,
  output logic [uart_rx_pkg::ENTRY_W-1:0]      got_data
);
  logic go_r;
  assign out_ready = en & go_r;
  // Stall about one cycle in three
  always @(negedge ref_clk) go_r <= ($urandom % 3) != 0;
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      got <= 1'b0;
      got_data <= '0;
    end else begin
      got <= out_valid & out_ready;
      got_data <= out_data;
    end
  end
endmodule // drain_model

// ### sim/testbench.sv
`timescale 1ns/1ps
module testbench;
  logic ref_clk = 1'b0, arst_n = 1'b0, char_valid = 1'b0, rx_in = 1'b1;
  logic en = 1'b0, clear_brk_end = 1'b0, clear_brk_begin = 1'b0;
  logic char_ready, out_valid, out_ready;
  logic [7:0] char_data = 8'h00, status_bits;
  logic [2:0] char_err = 3'h0;
  logic [10:0] out_data, got_data, q[$];
  logic err_flag, end_flag, begin_flag, dma_req, irq, got;
  logic brk = 1'b0, end_e = 1'b0, begin_e = 1'b0, armed = 1'b1;
  int error_cnt = 0, samples_checked = 0;
  always #5 ref_clk = ~ref_clk;
  rx_err_status rx_err_status_inst (.ref_clk(ref_clk), .arst_n(arst_n),
    .char_valid(char_valid), .char_ready(char_ready),
    .char_data(char_data), .char_err(char_err), .rx_in(rx_in),
    .clear_brk_end(clear_brk_end), .clear_brk_begin(clear_brk_begin),
    .out_valid(out_valid), .out_ready(out_ready), .out_data(out_data),
    .status_bits(status_bits), .error_in_fifo_flag(err_flag),
    .receive_end_of_break_flag(end_flag),
    .receive_break_begin_flag(begin_flag), .dma_req(dma_req), .irq(irq));
  drain_model drain_model_inst (.ref_clk(ref_clk), .arst_n(arst_n),
    .en(en), .out_valid(out_valid), .out_ready(out_ready),
    .out_data(out_data), .got(got), .got_data(got_data));
  task end_sim;
    $display("errors %0d checks %0d", error_cnt, samples_checked);
    if (error_cnt == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task chk(input logic [10:0] e, input logic [10:0] a, input string m);
    samples_checked++;
    if (e !== a) begin
      error_cnt++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask
  task stuck;
    error_cnt++;
    end_sim;
  endtask
  function logic err_f();
    for (int i = 0; i < 4 && i < q.size(); i++)
      if (q[i][10:8] != 3'h0) return 1'b1;
    return 1'b0;
  endfunction
  task flags;
    repeat (2) @(negedge ref_clk);
    chk(11'(err_f()), 11'(err_flag), "error flag");
    chk(11'(!err_f() && q.size() >= 5), 11'(dma_req), "dma request");
    chk(11'(err_f() | end_e), 11'(irq), "interrupt");
    chk(11'(end_e), 11'(end_flag), "end of break flag");
    chk(11'(begin_e), 11'(begin_flag), "break begin flag");
    chk(11'(q.size() > 0), 11'(out_valid), "fifo not empty");
    chk({5'h00, err_f(), end_e, begin_e, 3'h0},
        11'(status_bits), "status");
  endtask
  task push(input logic [7:0] d, input logic [2:0] e);
    int i;
    char_valid = 1'b1;
    char_data = d;
    char_err = e;
    for (i = 0; i < 20 && char_ready !== 1'b1; i++) @(negedge ref_clk);
    if (char_ready !== 1'b1) stuck;
    @(negedge ref_clk) char_valid = 1'b0;
    // Let an edge pass with valid low before the next request
    @(negedge ref_clk);
    if (!brk) q.push_back({e, d});
    if (!brk && armed && d == 8'h00 && e[1]) begin
      brk = 1'b1;
      begin_e = 1'b1;
      armed = 1'b0;
    end
  endtask
  task pop;
    int i;
    en = 1'b1;
    for (i = 0; i < 50; i++) begin
      @(negedge ref_clk);
      if (got === 1'b1) break;
    end
    en = 1'b0;
    if (got !== 1'b1) stuck;
    chk(q.pop_front(), got_data, "drained entry");
    @(negedge ref_clk);
  endtask
  task pulse(input logic which);
    if (which) clear_brk_begin = 1'b1;
    else clear_brk_end = 1'b1;
    @(negedge ref_clk);
    if (which) clear_brk_begin = 1'b0;
    else clear_brk_end = 1'b0;
  endtask
  task rise;
    rx_in = 1'b1;
    brk = 1'b0;
    end_e = 1'b1;
    armed = 1'b1;
    flags;
  endtask
  initial begin
    void'($urandom(30));
    repeat (4) @(negedge ref_clk);
    arst_n = 1;
    flags;
    chk(11'(char_ready), 11'h001, "ready after reset");
    // ==========
    // Fill to refusal: tag at entry five sits above bottom four
    for (int i = 0; i < 32; i++) begin
      push(8'($urandom) | 8'h01, (i < 5) ? 3'h0 : (i == 5) ? 3'h4 :
           ($urandom % 4 == 0) ? 3'(1 << ($urandom % 3)) : 3'h0);
      flags;
    end
    chk(11'(char_ready), 11'h000, "full refuses");
    while (q.size() > 0) begin
      pop;
      flags;
    end
    // ==========
    // Break: one null kept, rest dropped, clears leave the error flag
    rx_in = 1'b0;
    push(8'h00, 3'h2);
    push(8'h00, 3'h2);
    push(8'h41, 3'h0);
    pulse(1'b1);
    begin_e = 1'b0;
    pulse(1'b0);
    push(8'h00, 3'h2);
    flags;
    rise;
    push(8'h42, 3'h0);
    pulse(1'b0);
    end_e = 1'b0;
    rx_in = 1'b0;
    push(8'h00, 3'h2);
    flags;
    rise;
    while (q.size() > 0) pop;
    flags;
    end_sim;
  end
endmodule // testbench
